// File: hdl/cfg_pkg.sv
// constants for the wake-event and midi configuration register bank
package cfg_pkg;

    // ****************************************
    // register indices and byte addresses
    // ****************************************
    localparam int unsigned ADDR_W          = 12;
    localparam logic [7:0]  IDX_MIDI_HIGH   = 8'h60;
    localparam logic [7:0]  IDX_MIDI_LOW    = 8'h61;
    localparam logic [7:0]  IDX_SLOW_CLOCK  = 8'hF0;
    localparam logic [7:0]  IDX_FLOPPY_RTE  = 8'hF1;
    localparam logic [7:0]  IDX_ROUTE_STAT  = 8'hF8;
    localparam logic [ADDR_W-1:0] ADDR_MIDI_HIGH  = {2'h0, IDX_MIDI_HIGH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MIDI_LOW   = {2'h0, IDX_MIDI_LOW, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SLOW_CLOCK = {2'h0, IDX_SLOW_CLOCK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FLOPPY_RTE = {2'h0, IDX_FLOPPY_RTE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_ROUTE_STAT = {2'h0, IDX_ROUTE_STAT, 2'h0};

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [7:0] RST_MIDI_HIGH  = 8'h03;
    localparam logic [7:0] RST_MIDI_LOW   = 8'h30;
    localparam logic [7:0] RST_SLOW_CLOCK = 8'h00;
    localparam logic [7:0] RST_FLOPPY_RTE = 8'h00;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int unsigned BIT_CLOCK_ABSENT = 0;
    localparam int unsigned BIT_KEY_WAKE_OFF = 1;
    localparam logic [7:0]  MASK_SLOW_CLOCK  = 8'h03;
    localparam logic [7:0]  MASK_FLOPPY_RTE  = 8'h03;
    localparam logic [7:0]  MASK_MIDI_HIGH   = 8'h0F;
    localparam logic [7:0]  MASK_MIDI_LOW    = 8'hFE;
    localparam int unsigned BIT_STAT_SELECT  = 0;
    localparam int unsigned BIT_STAT_FLOPPY  = 1;
    localparam int unsigned BIT_STAT_DRIVE0  = 2;
    localparam int unsigned BIT_STAT_DRIVE1  = 3;
    localparam int unsigned BIT_STAT_KEYCLK  = 4;

    // ****************************************
    // floppy route field codes
    // ****************************************
    localparam logic [1:0] ROUTE_PORT_MODE  = 2'h0;
    localparam logic [1:0] ROUTE_PIN_DRIVE1 = 2'h1;
    localparam logic [1:0] ROUTE_PIN_BOTH   = 2'h2;
    localparam logic [1:0] ROUTE_RESERVED   = 2'h3;

    // ****************************************
    // bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hdl/floppy_route_logic.sv
// floppy controller routing onto the printer port pins
`timescale 1ns/10ps
module floppy_route_logic (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // route controls and results
    route_if.route    rt
);
    import cfg_pkg::*;

    // ****************************************
    // route decision
    // ****************************************
    logic next_floppy;
    logic next_drive0;
    logic next_drive1;

    always_comb begin
        next_floppy = 1'b0;
        next_drive0 = 1'b0;
        next_drive1 = 1'b0;
        case (rt.mode)
            ROUTE_PORT_MODE: begin
                // select pin not looked at here
                next_floppy = rt.port_mode_floppy;
                next_drive0 = rt.port_mode_floppy;
                next_drive1 = rt.port_mode_floppy;
            end
            ROUTE_PIN_DRIVE1: begin
                next_floppy = rt.select_low;
                next_drive1 = rt.select_low;
            end
            ROUTE_PIN_BOTH: begin
                next_floppy = rt.select_low;
                next_drive0 = rt.select_low;
                next_drive1 = rt.select_low;
            end
            // reserved code keeps the floppy on its own pins
            default: begin
                next_floppy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rt.floppy_moved <= 1'b0;
            rt.drive0_moved <= 1'b0;
            rt.drive1_moved <= 1'b0;
        end else begin
            rt.floppy_moved <= next_floppy;
            rt.drive0_moved <= next_drive0;
            rt.drive1_moved <= next_drive1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_pin_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        rt.mode == ROUTE_PORT_MODE |=> rt.floppy_moved == $past(rt.port_mode_floppy)
        && rt.drive0_moved == $past(rt.port_mode_floppy)
        && rt.drive1_moved == $past(rt.port_mode_floppy))
        else $error("printer mode bit not followed in mode 00");
    a_drive1_only: assert property (@(posedge aclk) disable iff (!aresetn)
        rt.mode == ROUTE_PIN_DRIVE1 && rt.select_low
        |=> rt.floppy_moved && !rt.drive0_moved && rt.drive1_moved)
        else $error("mode 01 routing wrong");
    a_drive_both: assert property (@(posedge aclk) disable iff (!aresetn)
        rt.mode == ROUTE_PIN_BOTH && rt.select_low
        |=> rt.floppy_moved && rt.drive0_moved && rt.drive1_moved)
        else $error("mode 10 routing wrong");
    a_pin_high_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (rt.mode == ROUTE_PIN_DRIVE1 || rt.mode == ROUTE_PIN_BOTH) && !rt.select_low
        |=> !rt.floppy_moved && !rt.drive0_moved && !rt.drive1_moved)
        else $error("floppy moved while select pin high");
endmodule

// File: hdl/route_if.sv
// carrier between the register bank and the floppy route logic
`timescale 1ns/10ps
interface route_if;
    logic [1:0] mode;
    logic       port_mode_floppy;
    logic       select_low;
    logic       floppy_moved;
    logic       drive0_moved;
    logic       drive1_moved;

    modport ctrl  (output mode, port_mode_floppy, select_low,
                   input  floppy_moved, drive0_moved, drive1_moved);
    modport route (input  mode, port_mode_floppy, select_low,
                   output floppy_moved, drive0_moved, drive1_moved);
endinterface

// File: hdl/wake_and_midi_config_regs.sv
// register bank for key-wake clock control, floppy routing and midi base address
//
// Contract
// - bit 0 flags the slow clock absent
// - bit 1 set turns key wake logic off
// - key wake off blocks its slow clock
// - field 00: printer mode bits decide, pin ignored
// - field 01: low pin moves drive 1
// - field 10: low pin moves both drives
// - midi base bit 0 and upper nibble zero
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module wake_and_midi_config_regs (
    // clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // axi4-lite write address
    input  wire logic [cfg_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                 awprot,
    input  wire logic                       awvalid,
    output logic                            awready,
    // axi4-lite write data
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // axi4-lite write response
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // axi4-lite read address
    input  wire logic [cfg_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                 arprot,
    input  wire logic                       arvalid,
    output logic                            arready,
    // axi4-lite read data
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // slow clock and key wake
    input  wire logic                       slow_clock_input_pin,
    output logic                            slow_clock_absent,
    output logic                            key_wake_logic_off,
    output logic                            key_wake_clock,
    // floppy routing
    input  wire logic                       floppy_route_select_n,
    input  wire logic                       port_mode_floppy,
    output logic                            floppy_on_printer_port,
    output logic                            drive0_on_printer_port,
    output logic                            drive1_on_printer_port,
    // midi uart base address
    output logic [11:0]                     midi_base_address
);
    import cfg_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    logic [7:0]        midi_high;
    logic [7:0]        midi_low;
    logic [7:0]        slow_clock_reg;
    logic [7:0]        route_reg;
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic              do_write;
    logic              wr_mapped;
    logic              rd_mapped;
    logic [31:0]       read_word;
    logic              sel_s1;
    logic              sel_s2;
    logic              sel_s3;
    logic              select_low;
    logic [7:0]        route_status;

    route_if rt ();

    // ****************************************
    // select pin synchroniser
    // ****************************************
    // first stage feeds the second only; change taken when stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            sel_s3 <= 1'b1;
        end else begin
            sel_s1 <= floppy_route_select_n;
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            select_low <= 1'b0;
        end else if (sel_s2 == sel_s3) begin
            select_low <= ~sel_s3;
        end
    end

    // ****************************************
    // write channel
    // ****************************************
    // address and data may arrive in either order; each is held until both are in
    assign awready  = !aw_held && !bvalid;
    assign wready   = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        case (aw_addr)
            ADDR_MIDI_HIGH, ADDR_MIDI_LOW, ADDR_SLOW_CLOCK,
            ADDR_FLOPPY_RTE, ADDR_ROUTE_STAT: wr_mapped = 1'b1;
            default:                          wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    // only byte lane 0 carries register bits; masks keep reserved bits at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_clock_reg <= RST_SLOW_CLOCK;
        end else if (do_write && w_strb[0] && aw_addr == ADDR_SLOW_CLOCK) begin
            slow_clock_reg <= w_data[7:0] & MASK_SLOW_CLOCK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_reg <= RST_FLOPPY_RTE;
        end else if (do_write && w_strb[0] && aw_addr == ADDR_FLOPPY_RTE) begin
            route_reg <= w_data[7:0] & MASK_FLOPPY_RTE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            midi_high <= RST_MIDI_HIGH;
            midi_low  <= RST_MIDI_LOW;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == ADDR_MIDI_HIGH) begin
                midi_high <= w_data[7:0] & MASK_MIDI_HIGH;
            end
            if (aw_addr == ADDR_MIDI_LOW) begin
                midi_low <= w_data[7:0] & MASK_MIDI_LOW;
            end
        end
    end

    // ****************************************
    // block outputs
    // ****************************************
    assign slow_clock_absent  = slow_clock_reg[BIT_CLOCK_ABSENT];
    assign key_wake_logic_off = slow_clock_reg[BIT_KEY_WAKE_OFF];
    // plain and-gate; a real chip puts a glitch-free gate cell here
    assign key_wake_clock     = slow_clock_input_pin & ~key_wake_logic_off;
    assign midi_base_address  = {midi_high[3:0], midi_low};

    assign rt.mode             = route_reg[1:0];
    assign rt.port_mode_floppy = port_mode_floppy;
    assign rt.select_low       = select_low;

    floppy_route_logic u_route (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rt      (rt.route)
    );

    assign floppy_on_printer_port = rt.floppy_moved;
    assign drive0_on_printer_port = rt.drive0_moved;
    assign drive1_on_printer_port = rt.drive1_moved;

    always_comb begin
        route_status                  = 8'h00;
        route_status[BIT_STAT_SELECT] = select_low;
        route_status[BIT_STAT_FLOPPY] = rt.floppy_moved;
        route_status[BIT_STAT_DRIVE0] = rt.drive0_moved;
        route_status[BIT_STAT_DRIVE1] = rt.drive1_moved;
        route_status[BIT_STAT_KEYCLK] = ~key_wake_logic_off;
    end

    // ****************************************
    // read channel
    // ****************************************
    assign arready = !rvalid;

    always_comb begin
        read_word = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (araddr)
            ADDR_MIDI_HIGH:  read_word[7:0] = midi_high;
            ADDR_MIDI_LOW:   read_word[7:0] = midi_low;
            ADDR_SLOW_CLOCK: read_word[7:0] = slow_clock_reg;
            ADDR_FLOPPY_RTE: read_word[7:0] = route_reg;
            ADDR_ROUTE_STAT: read_word[7:0] = route_status;
            default:         rd_mapped      = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= read_word;
            rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_absent_bit_write: assert property (
        do_write && w_strb[0] && aw_addr == ADDR_SLOW_CLOCK
        |=> slow_clock_absent == $past(w_data[BIT_CLOCK_ABSENT]))
        else $error("slow clock absent bit not stored");
    a_key_wake_write: assert property (
        do_write && w_strb[0] && aw_addr == ADDR_SLOW_CLOCK
        |=> key_wake_logic_off == $past(w_data[BIT_KEY_WAKE_OFF]))
        else $error("key wake off bit not stored");
    a_key_clock_gated: assert property (
        key_wake_logic_off |-> !key_wake_clock && !route_status[BIT_STAT_KEYCLK])
        else $error("slow clock reaches key wake logic while off");
    a_midi_low_zero: assert property (
        midi_base_address[0] == 1'b0 && midi_low[0] == 1'b0)
        else $error("midi base address bit 0 not zero");
    a_midi_high_nibble: assert property (
        do_write && w_strb[0] && aw_addr == ADDR_MIDI_HIGH
        |=> midi_high == ($past(w_data[7:0]) & MASK_MIDI_HIGH))
        else $error("midi high byte upper nibble not zero");
    a_reserved_read: assert property (
        arvalid && arready && (araddr == ADDR_SLOW_CLOCK || araddr == ADDR_FLOPPY_RTE)
        |=> rvalid && rdata[31:2] == 30'h0000_0000)
        else $error("reserved bits read nonzero");
    a_write_answer: assert property (
        do_write |=> bvalid && bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR))
        else $error("write answer missing or wrong");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid && rdata == $past(read_word))
        else $error("read answer missing or wrong");
    a_select_filter: assert property (
        select_low != $past(select_low) |-> $past(sel_s2) == $past(sel_s3))
        else $error("select pin taken before stages agreed");
    a_select_taken: assert property (
        sel_s2 == sel_s3 |=> select_low == !$past(sel_s3))
        else $error("agreed select pin level not taken");
    a_route_write: assert property (
        do_write && w_strb[0] && aw_addr == ADDR_FLOPPY_RTE
        |=> route_reg == ($past(w_data[7:0]) & MASK_FLOPPY_RTE))
        else $error("route field not stored or reserved bits set");
    // lane 0 off carries no register bits, so nothing may move
    a_lane_off_keeps: assert property (
        do_write && !w_strb[0] |=> $stable(slow_clock_reg) && $stable(route_reg)
        && $stable(midi_high) && $stable(midi_low))
        else $error("write with byte lane 0 off changed a register");
endmodule

// File: sim/wake_and_midi_config_regs_tb_top.sv
// self-checking bench for the key-wake, floppy route and midi base register bank
`timescale 1ns/10ps
module wake_and_midi_config_regs_tb_top;
    import cfg_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic              awvalid = 1'b0;
    logic              awready;
    logic [31:0]       wdata = '0;
    logic [3:0]        wstrb = '0;
    logic              wvalid = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready = 1'b0;
    logic [ADDR_W-1:0] araddr = '0;
    logic              arvalid = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready = 1'b0;
    logic              slow_clock_input_pin = 1'b0;
    logic              slow_clock_absent;
    logic              key_wake_logic_off;
    logic              key_wake_clock;
    logic              floppy_route_select_n = 1'b1;
    logic              port_mode_floppy = 1'b0;
    logic              floppy_on_printer_port;
    logic              drive0_on_printer_port;
    logic              drive1_on_printer_port;
    logic [11:0]       midi_base_address;
    int                n_mismatch = 0;
    int                samples_checked = 0;
    int                seed = 54;
    logic [7:0]        shadow [4];
    logic [ADDR_W-1:0] addr_tab [4] = '{ADDR_MIDI_HIGH, ADDR_MIDI_LOW, ADDR_SLOW_CLOCK,
                                        ADDR_FLOPPY_RTE};
    logic [7:0]        mask_tab [4] = '{MASK_MIDI_HIGH, MASK_MIDI_LOW, MASK_SLOW_CLOCK,
                                        MASK_FLOPPY_RTE};
    logic [7:0]        rst_tab [4] = '{RST_MIDI_HIGH, RST_MIDI_LOW, RST_SLOW_CLOCK,
                                       RST_FLOPPY_RTE};
    logic [ADDR_W-1:0] bad_tab [3] = '{12'h000, 12'h3FC, 12'h188};

    always #20 aclk = ~aclk;

    // free-running stand-in for the 32 kHz pin, so the gate sees both levels
    always @(posedge aclk) begin
        slow_clock_input_pin <= ~slow_clock_input_pin;
    end

    wake_and_midi_config_regs i_wake_and_midi_config_regs (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .slow_clock_input_pin(slow_clock_input_pin), .slow_clock_absent(slow_clock_absent),
        .key_wake_logic_off(key_wake_logic_off), .key_wake_clock(key_wake_clock),
        .floppy_route_select_n(floppy_route_select_n), .port_mode_floppy(port_mode_floppy),
        .floppy_on_printer_port(floppy_on_printer_port),
        .drive0_on_printer_port(drive0_on_printer_port),
        .drive1_on_printer_port(drive1_on_printer_port),
        .midi_base_address(midi_base_address)
    );

    // ****************************************
    // reporting
    // ****************************************
    task automatic test_done;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input string what);
        n_mismatch++;
        $display("FAIL %s expected answer seen none", what);
        test_done();
    endtask

    // ****************************************
    // bus tasks: ready judged at the negedge before the taking edge
    // ****************************************
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] resp);
        bit aw_done = 1'b0, w_done = 1'b0, aw_go, w_go, got = 1'b0;
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge aclk);
            aw_go = !aw_done && awready;
            w_go = !w_done && wready;
            @(posedge aclk);
            if (aw_go) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_go) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (++n > 50) give_up("write address or data");
        end
        n = 0;
        while (!got) begin
            @(negedge aclk);
            got = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (++n > 50) give_up("write response");
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        bit go = 1'b0, got = 1'b0;
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!go) begin
            @(negedge aclk);
            go = arready;
            @(posedge aclk);
            if (++n > 50) give_up("read address");
        end
        arvalid <= 1'b0;
        n = 0;
        while (!got) begin
            @(negedge aclk);
            got = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (++n > 50) give_up("read data");
        end
        rready <= 1'b0;
    endtask

    // ****************************************
    // expectations
    // ****************************************
    task automatic check_reg(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(addr_tab[i], d, r);
        check("register readback", d, {24'h0, shadow[i]});
        check("read response", 32'(r), 32'(RESP_OKAY));
    endtask

    task automatic check_outputs;
        repeat (4) begin
            @(negedge aclk);
            check("midi base", 32'(midi_base_address),
                  32'({shadow[0][3:0], shadow[1][7:1], 1'b0}));
            check("clock absent", 32'(slow_clock_absent), 32'(shadow[2][0]));
            check("key wake off", 32'(key_wake_logic_off), 32'(shadow[2][1]));
            check("key wake clock", 32'(key_wake_clock),
                  32'(slow_clock_input_pin & ~shadow[2][1]));
        end
    endtask

    function automatic logic [2:0] route_exp(input logic [1:0] m, input logic pl, input logic ppm);
        case (m)
            ROUTE_PORT_MODE:  route_exp = {ppm, ppm, ppm};
            ROUTE_PIN_DRIVE1: route_exp = pl ? 3'h5 : 3'h0;
            ROUTE_PIN_BOTH:   route_exp = pl ? 3'h7 : 3'h0;
            default:          route_exp = 3'h0;
        endcase
    endfunction

    task automatic reset_checks;
        for (int i = 0; i < 4; i++) begin
            shadow[i] = rst_tab[i];
            check_reg(i);
        end
        check_outputs();
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [3:0]  s;
        logic [2:0]  e;
        int          i;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        reset_checks();
        // random writes, some with the byte lane off so nothing may change
        repeat (24) begin
            i = int'($unsigned($random(seed)) % 4);
            d = $random(seed);
            s = (($random(seed) & 3) == 0) ? 4'hE : 4'hF;
            axi_write(addr_tab[i], d, s, r);
            check("write response", 32'(r), 32'(RESP_OKAY));
            if (s[0]) shadow[i] = d[7:0] & mask_tab[i];
            check_reg(i);
            check_outputs();
        end
        // all ones: reserved bits and midi low bit 0 must read zero
        for (i = 0; i < 4; i++) begin
            axi_write(addr_tab[i], 32'hFFFFFFFF, 4'hF, r);
            shadow[i] = mask_tab[i];
            check_reg(i);
        end
        check_outputs();
        // unmapped places answer with an error and change nothing
        foreach (bad_tab[k]) begin
            axi_write(bad_tab[k], 32'h00000000, 4'hF, r);
            check("unmapped write", 32'(r), 32'(RESP_SLVERR));
            axi_read(bad_tab[k], d, r);
            check("unmapped read", 32'(r), 32'(RESP_SLVERR));
            check("unmapped data", d, 32'h0);
        end
        for (i = 0; i < 4; i++) check_reg(i);
        // every route code against every pin and mode level
        for (int m = 0; m < 4; m++) begin
            axi_write(ADDR_FLOPPY_RTE, 32'(m), 4'hF, r);
            shadow[3] = 8'(m);
            for (int p = 0; p < 4; p++) begin
                @(posedge aclk);
                floppy_route_select_n <= ~p[0];
                port_mode_floppy <= p[1];
                repeat (10) @(posedge aclk);
                @(negedge aclk);
                e = route_exp(2'(m), p[0], p[1]);
                check("route pins", 32'({floppy_on_printer_port, drive0_on_printer_port,
                      drive1_on_printer_port}), 32'(e));
                axi_read(ADDR_ROUTE_STAT, d, r);
                check("route status", d, 32'({~shadow[2][1], e[0], e[1], e[2], p[0]}));
            end
        end
        // status is read-only: a write is answered okay and must leave the route register as it was
        axi_write(ADDR_ROUTE_STAT, 32'h000000FF, 4'hF, r);
        check("status write", 32'(r), 32'(RESP_OKAY));
        check_reg(3);
        // second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        floppy_route_select_n <= 1'b1;
        port_mode_floppy <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        reset_checks();
        test_done();
    end
endmodule
